// ### tpg_cfg.svh
// register map, field positions and reset values of the three pin block
// assumes inclusion by bare name from every design file that needs it
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH

// ------------------------------------------------------------------
// register addresses
// ------------------------------------------------------------------
`define TPG_ADDR_W          8
`define TPG_ADDR_PIN12      8'h1B
`define TPG_ADDR_PIN3       8'h1C

// ------------------------------------------------------------------
// pin_one_two_config fields
// ------------------------------------------------------------------
`define TPG_B_P2_DIR        7
`define TPG_B_P1_DIR        6
`define TPG_B_P2_OUT        5
`define TPG_B_P1_OUT        4
`define TPG_B_P2_SEL        3
`define TPG_B_P1_SEL        2
`define TPG_B_P1_SBY        1
`define TPG_B_P1_CONV1      0

// ------------------------------------------------------------------
// pin_three_and_misc_config fields
// ------------------------------------------------------------------
`define TPG_B_P3_DIR        7
`define TPG_B_P3_OUT        6
`define TPG_B_REG0_EN       5
`define TPG_B_CHG_SEL       4
`define TPG_B_UNUSED        3
`define TPG_B_P2_IRQ        2
`define TPG_B_P1_IRQ        1
`define TPG_B_P2_CONV2      0

// ------------------------------------------------------------------
// reset values and masks
// ------------------------------------------------------------------
`define TPG_RST_PIN12       8'h00
`define TPG_RST_PIN3        8'h00
`define TPG_PIN3_WMASK      8'hF7
`define TPG_RST_RDATA       8'h00
`define TPG_PIN_IDLE        1'b1
`define TPG_PIN_CNT         3

`endif

// ### tpg_gpio.sv
// three open-drain pins: outputs, edge interrupts, converter control, conversion trigger
// assumes register accesses come as byte strobes from the serial host port
// and converter requests from the register side arrive as levels
`timescale 1ns/10ps
`include "tpg_cfg.svh"

// How it works
// - a pin one or two set as output floats when its level bit is 1 and pulls low when 0.
// - pin three set as output floats when its level bit is 1 and pulls low when 0.
// - pin three as input with trigger enabled starts a conversion on the rising edge if the edge bit is high, else falling.
// - pin two as input with interrupt on and converter-two control off pulls the interrupt low on the chosen edge, falling for 1.
// - pin one as input with interrupt on and both its converter controls off pulls the interrupt low on the chosen edge, falling for 1.
// - pin two as input with interrupt off and converter-two control on turns converter two on while the pin matches the select bit.
// - pin one as input with only converter-one control on turns converter one on while the pin matches the select bit.
// - pin one as input with only standby control on puts both converters in standby while the pin matches the select bit.
// - the pin one and two register sits at address 1B and the pin three register at 1C.
// - every bit of both registers except bit 3 of 1C is writable and reads back the last written value; that bit reads 0.
// - an edge interrupt is released only after two chosen edges followed by a host read.
// - an undervoltage event or turning the pin into an output also releases the interrupt.
// - every pin passes two flip-flops before the edge logic sees it.
// - a converter under pin control runs only when register and pin both ask, and idles only when both ask standby.
module tpg_gpio (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_ce,
  input  wire logic [2:0]             i_pin_i,
  output logic      [2:0]             o_pin_o,
  output logic      [2:0]             o_pin_oe,
  input  wire logic                   i_reg_we,
  input  wire logic                   i_reg_rd,
  input  wire logic [`TPG_ADDR_W-1:0] i_reg_addr,
  input  wire logic [7:0]             i_reg_wdata,
  output logic      [7:0]             o_reg_rdata,
  input  wire logic                   i_undervoltage_lockout,
  input  wire logic                   i_pin_three_conv_trigger_en,
  input  wire logic                   i_pin_three_trigger_edge,
  input  wire logic                   i_buck_one_en,
  input  wire logic                   i_buck_two_en,
  input  wire logic                   i_buck_standby,
  output logic                        o_buck_one_en,
  output logic                        o_buck_two_en,
  output logic                        o_buck_standby,
  output logic                        o_conv_start,
  output logic                        o_int_n,
  output logic                        o_regulator_zero_enable,
  output logic                        o_charge_voltage_select
);

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  logic [7:0] pin12_reg;
  logic [7:0] pin3_reg;
  logic       hit12;
  logic       hit3;

  assign hit12 = (i_reg_addr == `TPG_ADDR_PIN12);
  assign hit3  = (i_reg_addr == `TPG_ADDR_PIN3);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin12_reg <= `TPG_RST_PIN12;
      pin3_reg  <= `TPG_RST_PIN3;
    end else if (i_ce && i_reg_we) begin
      if (hit12) begin
        pin12_reg <= i_reg_wdata;
      end
      if (hit3) begin
        pin3_reg <= i_reg_wdata & `TPG_PIN3_WMASK;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= `TPG_RST_RDATA;
    end else if (i_ce && i_reg_rd) begin
      if (hit12) begin
        o_reg_rdata <= pin12_reg;
      end else if (hit3) begin
        o_reg_rdata <= pin3_reg;
      end else begin
        o_reg_rdata <= `TPG_RST_RDATA;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_regulator_zero_enable <= 1'b0;
      o_charge_voltage_select <= 1'b0;
    end else if (i_ce) begin
      o_regulator_zero_enable <= pin3_reg[`TPG_B_REG0_EN];
      o_charge_voltage_select <= pin3_reg[`TPG_B_CHG_SEL];
    end
  end

  // ------------------------------------------------------------------
  // field views
  // ------------------------------------------------------------------
  logic [2:0] dir;
  logic [2:0] out_lvl;
  logic [1:0] sel;
  logic [1:0] irq_en;
  logic       conv1_ctl;
  logic       sby_ctl;
  logic       conv2_ctl;

  assign dir       = {pin3_reg[`TPG_B_P3_DIR], pin12_reg[`TPG_B_P2_DIR],
                      pin12_reg[`TPG_B_P1_DIR]};
  assign out_lvl   = {pin3_reg[`TPG_B_P3_OUT], pin12_reg[`TPG_B_P2_OUT],
                      pin12_reg[`TPG_B_P1_OUT]};
  assign sel       = {pin12_reg[`TPG_B_P2_SEL], pin12_reg[`TPG_B_P1_SEL]};
  assign irq_en    = {pin3_reg[`TPG_B_P2_IRQ], pin3_reg[`TPG_B_P1_IRQ]};
  assign conv1_ctl = pin12_reg[`TPG_B_P1_CONV1];
  assign sby_ctl   = pin12_reg[`TPG_B_P1_SBY];
  assign conv2_ctl = pin3_reg[`TPG_B_P2_CONV2];

  // ------------------------------------------------------------------
  // pin input synchroniser
  // ------------------------------------------------------------------
  tpg_pin_if #(.N(`TPG_PIN_CNT)) pins ();

  tpg_pin_sync #(.N(`TPG_PIN_CNT)) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_ce  (i_ce),
    .i_pin (i_pin_i),
    .pins  (pins.src)
  );

  // ------------------------------------------------------------------
  // open-drain drivers: enable only to pull low
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_o  <= 3'h0;
      o_pin_oe <= 3'h0;
    end else if (i_ce) begin
      o_pin_o  <= 3'h0;
      o_pin_oe <= dir & ~out_lvl;
    end
  end

  // ------------------------------------------------------------------
  // conversion trigger on pin three
  // ------------------------------------------------------------------
  logic trig_edge;

  assign trig_edge = i_pin_three_trigger_edge ? pins.rise[2] : pins.fall[2];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_conv_start <= 1'b0;
    end else if (i_ce) begin
      o_conv_start <= ~dir[2] & i_pin_three_conv_trigger_en & trig_edge;
    end
  end

  // ------------------------------------------------------------------
  // edge interrupts for pins one and two
  // ------------------------------------------------------------------
  logic [1:0] irq_mode;
  logic [1:0] irq_edge;
  logic [1:0] irq_active;
  tpg_pkg::tpg_irq_state_t irq_state_reg [2];

  assign irq_mode[0] = ~dir[0] & irq_en[0] & ~conv1_ctl & ~sby_ctl;
  assign irq_mode[1] = ~dir[1] & irq_en[1] & ~conv2_ctl;

  for (genvar k = 0; k < 2; k++) begin : g_irq
    tpg_pkg::tpg_irq_state_t irq_state_next;
    logic                    release_hw;

    // falling edge when the select bit is 1
    assign irq_edge[k]   = irq_mode[k] & (sel[k] ? pins.fall[k] : pins.rise[k]);
    assign release_hw    = i_undervoltage_lockout | dir[k];
    assign irq_active[k] = (irq_state_reg[k] != tpg_pkg::IRQ_IDLE);

    always_comb begin
      irq_state_next = irq_state_reg[k];
      case (irq_state_reg[k])
        tpg_pkg::IRQ_IDLE: begin
          if (irq_edge[k] && !i_undervoltage_lockout) begin
            irq_state_next = tpg_pkg::IRQ_SET;
          end
        end
        tpg_pkg::IRQ_SET: begin
          if (release_hw) begin
            irq_state_next = tpg_pkg::IRQ_IDLE;
          end else if (irq_edge[k]) begin
            irq_state_next = tpg_pkg::IRQ_ARMED;
          end
        end
        tpg_pkg::IRQ_ARMED: begin
          if (release_hw) begin
            irq_state_next = tpg_pkg::IRQ_IDLE;
          end else if (i_reg_rd && irq_edge[k]) begin
            irq_state_next = tpg_pkg::IRQ_SET;    // new edge beats the read
          end else if (i_reg_rd) begin
            irq_state_next = tpg_pkg::IRQ_IDLE;
          end
        end
        default: begin
          irq_state_next = tpg_pkg::IRQ_IDLE;
        end
      endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        irq_state_reg[k] <= tpg_pkg::IRQ_IDLE;
      end else if (i_ce) begin
        irq_state_reg[k] <= irq_state_next;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_int_n <= 1'b1;
    end else if (i_ce) begin
      o_int_n <= ~|irq_active;
    end
  end

  // ------------------------------------------------------------------
  // converter control
  // ------------------------------------------------------------------
  logic conv1_mode;
  logic sby_mode;
  logic conv2_mode;
  logic pin_conv1_req;
  logic pin_sby_req;
  logic pin_conv2_req;

  assign conv1_mode    = ~dir[0] & ~irq_en[0] & ~sby_ctl & conv1_ctl;
  assign sby_mode      = ~dir[0] & ~irq_en[0] & ~conv1_ctl & sby_ctl;
  assign conv2_mode    = ~dir[1] & ~irq_en[1] & conv2_ctl;
  // a pin that does not control a converter never vetoes the register side
  assign pin_conv1_req = ~conv1_mode | (pins.level[0] == sel[0]);
  assign pin_sby_req   = ~sby_mode | (pins.level[0] == sel[0]);
  assign pin_conv2_req = ~conv2_mode | (pins.level[1] == sel[1]);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_buck_one_en  <= 1'b0;
      o_buck_two_en  <= 1'b0;
      o_buck_standby <= 1'b0;
    end else if (i_ce) begin
      o_buck_one_en  <= i_buck_one_en & pin_conv1_req;
      o_buck_two_en  <= i_buck_two_en & pin_conv2_req;
      o_buck_standby <= i_buck_standby & pin_sby_req;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_pin_low_drive: assert property (i_ce && dir[0] && !out_lvl[0] |=> o_pin_oe[0] && !o_pin_o[0])
    else $error("pin one output low not driven");
  a_pin_three_float: assert property (i_ce && dir[2] && out_lvl[2] |=> !o_pin_oe[2])
    else $error("pin three not released");
  a_conv_start_cause: assert property (o_conv_start |-> $past(i_ce && !dir[2] && i_pin_three_conv_trigger_en && trig_edge))
    else $error("conversion start without its edge");
  a_int_pin_two: assert property (i_ce && irq_edge[1] && !i_undervoltage_lockout && !irq_active[0] ##1 i_ce |=> !o_int_n)
    else $error("pin two edge did not assert interrupt");
  a_int_pin_one: assert property (i_ce && irq_mode[0] && (sel[0] ? pins.fall[0] : pins.rise[0]) && !i_undervoltage_lockout ##1 i_ce |=> !o_int_n)
    else $error("pin one edge did not assert interrupt");
  a_buck_two_gate: assert property (i_ce |=> o_buck_two_en == $past(i_buck_two_en && (!conv2_mode || pins.level[1] == sel[1])))
    else $error("converter two enable wrong");
  a_buck_one_gate: assert property (i_ce && conv1_mode && i_buck_one_en && pins.level[0] != sel[0] |=> !o_buck_one_en)
    else $error("converter one on against pin");
  a_standby_gate: assert property (i_ce && sby_mode && i_buck_standby |=> o_buck_standby == $past(pins.level[0] == sel[0]))
    else $error("standby does not follow pin");
  a_reg_readback: assert property (i_ce && i_reg_we && hit12 ##1 i_ce && i_reg_rd && hit12 && !i_reg_we |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("register 1B readback mismatch");
  a_reg3_readback: assert property (i_ce && i_reg_we && hit3 ##1 i_ce && i_reg_rd && hit3 && !i_reg_we |=> o_reg_rdata == ($past(i_reg_wdata, 2) & `TPG_PIN3_WMASK))
    else $error("register 1C readback mismatch");
  a_int_release: assert property ($rose(o_int_n) |-> $past(i_reg_rd || i_undervoltage_lockout || dir[0] || dir[1], 2))
    else $error("interrupt released without cause");
  a_undervoltage_lockout_release: assert property (i_ce && i_undervoltage_lockout ##1 i_ce |=> o_int_n)
    else $error("undervoltage did not release interrupt");
  a_unused_zero: assert property (i_ce && i_reg_rd && hit3 |=> !o_reg_rdata[`TPG_B_UNUSED])
    else $error("unused bit reads one");

  c_int_asserted: cover property (o_int_n ##1 !o_int_n);
  c_int_cleared: cover property (irq_state_reg[0] == tpg_pkg::IRQ_ARMED ##1 i_ce && i_reg_rd ##2 o_int_n);
  c_conv_start: cover property (o_conv_start);
  c_standby: cover property (sby_mode && o_buck_standby);

endmodule

// ### tpg_gpio_tb_top.sv
// self-checking bench for the three pin block
// assumes the pin partner model and the design files are compiled first
`timescale 1ns/10ps
`include "tpg_cfg.svh"

module tpg_gpio_tb_top;
  logic       i_clk     = 1'b0;
  logic       i_rst     = 1'b1;
  logic       ce        = 1'b1;
  logic       reg_we    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       undervoltage_lockout      = 1'b0;
  logic       trg_en    = 1'b0;
  logic       trg_edge  = 1'b0;
  logic [2:0] buck_req  = 3'h0;
  logic [2:0] ext_low   = 3'h0;
  logic [2:0] pin_lvl;
  logic [2:0] pin_o;
  logic [2:0] pin_oe;
  logic [7:0] rdata;
  logic [1:0] misc;
  logic       buck1;
  logic       buck2;
  logic       sby;
  logic       conv;
  logic       int_n;
  logic       rd_d1     = 1'b0;
  logic       rd_d2     = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] v12;
  logic [7:0] v3;
  int         n_mismatch = 0;
  int         checks     = 0;
  int         conv_cnt   = 0;
  int         seed       = 32'h68485935;

  always #50 i_clk = ~i_clk;

  tpg_pin_drv pdrv (.i_pin_o(pin_o), .i_pin_oe(pin_oe), .i_ext_low(ext_low), .o_level(pin_lvl));

  tpg_gpio uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_pin_i(pin_lvl), .o_pin_o(pin_o),
    .o_pin_oe(pin_oe), .i_reg_we(reg_we), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata), .i_undervoltage_lockout(undervoltage_lockout),
    .i_pin_three_conv_trigger_en(trg_en), .i_pin_three_trigger_edge(trg_edge),
    .i_buck_one_en(buck_req[0]), .i_buck_two_en(buck_req[1]), .i_buck_standby(buck_req[2]),
    .o_buck_one_en(buck1), .o_buck_two_en(buck2), .o_buck_standby(sby),
    .o_conv_start(conv), .o_int_n(int_n), .o_regulator_zero_enable(misc[1]),
    .o_charge_voltage_select(misc[0])
  );

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    chk(got, exp, "read data");
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge i_clk);
    reg_we <= 1'b0;
  endtask

  // the expected byte is noted here and checked by the read monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clk);
    reg_rd <= 1'b0;
  endtask

  // write then read back in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge i_clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge i_clk);
    reg_we <= 1'b0;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic pin(input int k, input logic lo);
    @(posedge i_clk);
    ext_low[k] <= lo;
    step(6);
  endtask

  task automatic conv_case(input logic [7:0] b, input logic [7:0] c, input logic [2:0] req,
                           input logic [2:0] ext, input logic [2:0] e);
    wr(`TPG_ADDR_PIN12, b);
    wr(`TPG_ADDR_PIN3, c);
    @(posedge i_clk);
    buck_req <= req;
    ext_low  <= ext;
    step(6);
    chk({5'h00, sby, buck2, buck1}, {5'h00, e}, "converter outputs");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // monitors and watchdog
  // ------------------------------------------------------------------
  always @(posedge i_clk) begin
    rd_d1 <= reg_rd;
    rd_d2 <= rd_d1;
    if (conv === 1'b1) conv_cnt++;
  end

  initial forever begin
    @(posedge i_clk);
    #1;
    if (rd_d2 === 1'b1 && exp_q.size() > 0) chk_rd(rdata, exp_q.pop_front());
  end

  initial begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    step(1);
    chk({int_n, pin_oe, buck1, buck2, sby, conv}, 8'h80, "reset outputs");
    rd(`TPG_ADDR_PIN12, `TPG_RST_PIN12);
    rd(`TPG_ADDR_PIN3, `TPG_RST_PIN3);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v12 = $random(seed);
      v3  = $random(seed);
      wr_rd(`TPG_ADDR_PIN12, v12, v12);
      wr_rd(`TPG_ADDR_PIN3, v3, v3 & 8'hF7);
      step(1);
      chk({6'h00, misc}, {6'h00, v3[5:4]}, "misc copies");
      chk({5'h00, pin_oe}, {5'h00, v3[7] & ~v3[6], v12[7] & ~v12[5], v12[6] & ~v12[4]}, "oe");
    end
    for (int j = 0; j < 4; j++) begin
      wr(`TPG_ADDR_PIN12, {2'b11, j[1:0], 4'h0});
      wr(`TPG_ADDR_PIN3, {1'b1, j[0], 6'h00});
      step(2);
      chk({5'h00, pin_oe}, {5'h00, ~j[0], ~j[1], ~j[0]}, "open drain");
      chk({5'h00, pin_lvl}, {5'h00, j[0], j[1], j[0]}, "pin level");
      chk({5'h00, pin_o}, 8'h00, "drive value");
    end
    @(posedge i_clk);
    ce <= 1'b0;
    wr(`TPG_ADDR_PIN12, 8'h00);
    @(posedge i_clk);
    ce <= 1'b1;
    rd(`TPG_ADDR_PIN12, 8'hF0);
    wr(8'h1D, 8'hFF);
    rd(8'h1D, 8'h00);
    rd(`TPG_ADDR_PIN3, 8'hC0);
    $display("test registers done");
    wr(`TPG_ADDR_PIN12, 8'h00);
    wr(`TPG_ADDR_PIN3, 8'h00);
    @(posedge i_clk);
    trg_en   <= 1'b1;
    trg_edge <= 1'b1;
    conv_cnt = 0;
    pin(2, 1'b1);
    chk(conv_cnt[7:0], 8'h00, "no start on falling");
    pin(2, 1'b0);
    chk(conv_cnt[7:0], 8'h01, "start on rising");
    @(posedge i_clk);
    trg_edge <= 1'b0;
    pin(2, 1'b1);
    pin(2, 1'b0);
    chk(conv_cnt[7:0], 8'h02, "start on falling");
    @(posedge i_clk);
    trg_en <= 1'b0;
    pin(2, 1'b1);
    pin(2, 1'b0);
    chk(conv_cnt[7:0], 8'h02, "trigger disabled");
    $display("test trigger done");
    wr(`TPG_ADDR_PIN3, 8'h02);
    wr(`TPG_ADDR_PIN12, 8'h04);
    pin(0, 1'b1);
    chk({7'h00, int_n}, 8'h00, "pin one falling asserts");
    rd(`TPG_ADDR_PIN12, 8'h04);
    step(4);
    chk({7'h00, int_n}, 8'h00, "read after one edge");
    pin(0, 1'b0);
    pin(0, 1'b1);
    chk({7'h00, int_n}, 8'h00, "armed still low");
    rd(`TPG_ADDR_PIN3, 8'h02);
    step(4);
    chk({7'h00, int_n}, 8'h01, "read releases");
    pin(0, 1'b0);
    @(posedge i_clk);
    ext_low[1] <= 1'b1;
    wr(`TPG_ADDR_PIN3, 8'h04);
    wr(`TPG_ADDR_PIN12, 8'h00);
    pin(1, 1'b0);
    chk({7'h00, int_n}, 8'h00, "pin two rising asserts");
    @(posedge i_clk);
    undervoltage_lockout <= 1'b1;
    step(4);
    chk({7'h00, int_n}, 8'h01, "lockout releases");
    @(posedge i_clk);
    undervoltage_lockout <= 1'b0;
    pin(1, 1'b1);
    pin(1, 1'b0);
    chk({7'h00, int_n}, 8'h00, "asserted again");
    wr(`TPG_ADDR_PIN12, 8'hA0);
    step(4);
    chk({7'h00, int_n}, 8'h01, "output mode releases");
    $display("test interrupt done");
    conv_case(8'h08, 8'h01, 3'b011, 3'b000, 3'b011);
    conv_case(8'h08, 8'h01, 3'b011, 3'b010, 3'b001);
    conv_case(8'h08, 8'h01, 3'b001, 3'b000, 3'b001);
    conv_case(8'h01, 8'h00, 3'b011, 3'b001, 3'b011);
    conv_case(8'h01, 8'h00, 3'b011, 3'b000, 3'b010);
    conv_case(8'h06, 8'h00, 3'b111, 3'b000, 3'b111);
    conv_case(8'h06, 8'h00, 3'b111, 3'b001, 3'b011);
    conv_case(8'h06, 8'h00, 3'b011, 3'b000, 3'b011);
    $display("test converter done");
    step(4);
    print_verdict();
  end
endmodule

// ### tpg_pin_drv.sv
// partner model: outside drivers and pull-ups on the three open-drain pins
// assumes the device only ever pulls a pin low through its enable
`timescale 1ns/10ps

module tpg_pin_drv (
  input  wire logic [2:0] i_pin_o,
  input  wire logic [2:0] i_pin_oe,
  input  wire logic [2:0] i_ext_low,
  output logic      [2:0] o_level
);
  // wired-and of device pull, outside pull and pull-up; released pins read high
  assign o_level = ~((i_pin_oe & ~i_pin_o) | i_ext_low);
endmodule

// ### tpg_pin_if.sv
// carrier for synchronised pin levels and edge pulses
// assumes one clock shared by producer and consumer
`timescale 1ns/10ps

interface tpg_pin_if #(
  parameter int N = 3
);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;

  modport src (output level, output rise, output fall);
  modport dst (input  level, input  rise, input  fall);
endinterface

// ### tpg_pin_sync.sv
// two-stage pin synchroniser with edge detection after the second stage
// assumes pins may change at any time relative to i_clk
`timescale 1ns/10ps
`include "tpg_cfg.svh"

module tpg_pin_sync #(
  parameter int N = 3
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic [N-1:0] i_pin,
  tpg_pin_if.src            pins
);

  logic [N-1:0] stage1_reg;
  logic [N-1:0] stage2_reg;
  logic [N-1:0] prev_reg;

  // ------------------------------------------------------------------
  // synchroniser and edge history, one lane per pin
  // ------------------------------------------------------------------
  for (genvar k = 0; k < N; k++) begin : g_lane
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        // pins idle high on their pull-ups, so no false edge follows reset
        stage1_reg[k] <= `TPG_PIN_IDLE;
        stage2_reg[k] <= `TPG_PIN_IDLE;
        prev_reg[k]   <= `TPG_PIN_IDLE;
      end else if (i_ce) begin
        stage1_reg[k] <= i_pin[k];
        stage2_reg[k] <= stage1_reg[k];
        prev_reg[k]   <= stage2_reg[k];
      end
    end
  end

  assign pins.level = stage2_reg;
  assign pins.rise  = stage2_reg & ~prev_reg;
  assign pins.fall  = ~stage2_reg & prev_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_sync_two_stage: assert property (i_ce ##1 i_ce |=> pins.level == $past(i_pin, 2))
    else $error("pin level not delayed by two stages");

endmodule

// ### tpg_pkg.sv
// types shared by the three pin block
// assumes nothing beyond a SystemVerilog compiler
package tpg_pkg;

  // ------------------------------------------------------------------
  // edge interrupt hold state, one-hot
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    IRQ_IDLE  = 3'h1,
    IRQ_SET   = 3'h2,
    IRQ_ARMED = 3'h4
  } tpg_irq_state_t;

endpackage
